// file: clk_seq_pkg.sv
// shared constants, types and helpers for the core clock and reset sequencer
package clk_seq_pkg;

    localparam int MULT_W      = 5;
    localparam int DIV_W       = 16;
    localparam int ACC_W       = DIV_W + 1;
    localparam int N_SPORT     = 4;
    localparam int N_CLKGEN    = N_SPORT + 1;
    localparam int SPI_IDX     = N_SPORT;
    localparam int CNT_W       = 13;
    localparam int SYNC_STAGES = 2;

    // input clock timing
    localparam int IN_PERIOD_NS        = 100;
    localparam int IN_PERIOD_PS        = IN_PERIOD_NS * 1000;
    localparam int CORE_RST_CYCLES     = 4096;
    localparam int CORE_RST_MAX_CYCLES = 4097;
    localparam int CORE_CNT_LAST       = CORE_RST_CYCLES - SYNC_STAGES;
    localparam int WRST_MIN_CYCLES     = 4;
    localparam int INPUT_CLOCK_SETUP_US      = 10;
    localparam int INPUT_CLOCK_SETUP_CYCLES  = (INPUT_CLOCK_SETUP_US * 1000 + IN_PERIOD_NS - 1) / IN_PERIOD_NS;
    localparam int PLL_SETUP_US        = 20;
    localparam int PLL_SETUP_CYCLES    = (PLL_SETUP_US * 1000 + IN_PERIOD_NS - 1) / IN_PERIOD_NS;
    localparam int PLL_LOCK_US         = 100;
    localparam int PLL_LOCK_CYCLES     = (PLL_LOCK_US * 1000) / IN_PERIOD_NS;
    localparam int CORE_CLOCK_MIN_PS         = 6660;
    localparam int CORE_CLOCK_MAX_PS         = 10000;

    // ratio select pin codes and multipliers
    localparam logic [1:0]        RS_3X        = 2'h0;
    localparam logic [1:0]        RS_16X       = 2'h1;
    localparam logic [1:0]        RS_8X        = 2'h2;
    localparam logic [MULT_W-1:0] MULT_3X      = 5'h03;
    localparam logic [MULT_W-1:0] MULT_8X      = 5'h08;
    localparam logic [MULT_W-1:0] MULT_16X     = 5'h10;
    localparam logic [1:0]        PINS_RST     = RS_3X;
    localparam logic [MULT_W-1:0] PIN_MULT_RST = MULT_3X;

    // register map
    localparam logic [31:0] OFS_PM     = 32'h0000_0000;
    localparam logic [31:0] OFS_STATUS = 32'h0000_0004;
    localparam logic [31:0] OFS_DIV0   = 32'h0000_0008;
    localparam logic [31:0] OFS_LAST   = 32'h0000_0018;
    localparam logic [2:0]  IDX_PM     = OFS_PM[4:2];
    localparam logic [2:0]  IDX_STATUS = OFS_STATUS[4:2];
    localparam logic [2:0]  IDX_DIV0   = OFS_DIV0[4:2];
    localparam logic [2:0]  IDX_LAST   = OFS_LAST[4:2];
    localparam int          N_REGS     = 7;

    localparam int PM_MULT_POS   = 0;
    localparam int PM_OVR_POS    = 8;
    localparam int ST_MULT_POS   = 0;
    localparam int ST_PINS_POS   = 8;
    localparam int ST_CORE_POS   = 12;
    localparam int ST_REJECT_POS = 16;

    localparam logic [DIV_W-1:0] DIV_RST     = 16'h0000;
    localparam logic [1:0]       RESP_OKAY   = 2'h0;
    localparam logic [1:0]       RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic              ovr;
        logic [MULT_W-1:0] mult;
    } pm_ctl_t;

    localparam pm_ctl_t PM_RST = '{ovr: 1'b0, mult: 5'h00};

    function automatic logic [MULT_W-1:0] pin_ratio_decode(input logic [1:0] p);
        return (p == RS_16X) ? MULT_16X : (p == RS_8X) ? MULT_8X : MULT_3X;
    endfunction

    function automatic logic ratio_legal(input logic [MULT_W-1:0] m);
        int mi;
        mi = int'(m);
        return (mi * CORE_CLOCK_MIN_PS <= IN_PERIOD_PS) && (mi * CORE_CLOCK_MAX_PS >= IN_PERIOD_PS);
    endfunction

    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] data,
                                           input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
            if (strb[b])
                r[8*b +: 8] = data[8*b +: 8];
        return r;
    endfunction

endpackage

// file: port_clock_gen.sv
// programmable port clock divider driven by the modelled core clock rate
`timescale 1ns/10ps
module port_clock_gen
    import clk_seq_pkg::*;
(
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic              run,
    input  wire logic [MULT_W-1:0] mult,
    input  wire logic [DIV_W-1:0]  ratio,
    output logic                   clk_out
);

    logic [ACC_W-1:0]  acc_r;
    logic              clk_r;
    logic [DIV_W-1:0]  since_r;
    logic [MULT_W-1:0] mult_q_r;
    logic [DIV_W-1:0]  ratio_q_r;
    logic              same_r;

    // every input clock adds mult core periods; half period is ratio/2 core periods
    wire             go      = run && (ratio >= DIV_W'(2));
    wire [ACC_W-1:0] acc_sum = acc_r + ACC_W'({mult, 1'b0});
    wire             toggle  = go && (acc_sum >= ACC_W'(ratio));
    wire [ACC_W-1:0] acc_nxt = !go ? '0 : toggle ? acc_sum - ACC_W'(ratio) : acc_sum;
    wire             cfg_chg = !run || (mult != mult_q_r) || (ratio != ratio_q_r);
    wire [DIV_W-1:0] two_mult = DIV_W'({mult, 1'b0});

    assign clk_out = clk_r;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            acc_r <= '0;
            clk_r <= 1'b0;
        end
        else
        begin
            acc_r <= acc_nxt;
            clk_r <= go ? (clk_r ^ toggle) : 1'b0;
        end
    end

    // checking aids
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            since_r   <= '0;
            mult_q_r  <= '0;
            ratio_q_r <= '0;
            same_r    <= 1'b0;
        end
        else
        begin
            since_r   <= toggle ? '0 : DIV_W'(since_r + 1'b1);
            mult_q_r  <= mult;
            ratio_q_r <= ratio;
            same_r    <= cfg_chg ? 1'b0 : (toggle ? (acc_nxt < ACC_W'(two_mult)) : same_r);
        end
    end

    a_half_period: assert property (@(posedge aclk) disable iff (!aresetn)
        (toggle && same_r && !cfg_chg && mult != '0 && (ratio % two_mult) == '0)
        |-> since_r == DIV_W'(ratio / two_mult - 1'b1))
        else $error("port clock half period differs from ratio");

endmodule

// file: core_clock_reset_sequencer.sv
// core clock ratio control, port clock dividers and core reset sequencing
`timescale 1ns/10ps
// Functional notes
// - core ratio latched from pins during reset
// - port clocks divide core clock by ratio
// - pins give 3, 8, 16; software more
// - core reset held 4096 cycles after release
// - late capture may add one cycle, max 4097
module core_clock_reset_sequencer
    import clk_seq_pkg::*;
(
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [31:0]       awaddr,
    input  wire logic [2:0]        awprot,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    input  wire logic [31:0]       araddr,
    input  wire logic [2:0]        arprot,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    input  wire logic              ext_reset_n,
    input  wire logic [1:0]        clock_ratio_select_pins,
    output logic                   core_reset_n,
    output logic [MULT_W-1:0]      core_clock_mult,
    output logic [N_SPORT-1:0]     serial_port_clk,
    output logic                   spi_clk
);

    logic              ext_sync1_r;
    logic              ext_sync2_r;
    logic [1:0]        pins_latched_r;
    logic [MULT_W-1:0] pin_mult_r;
    logic [MULT_W-1:0] core_mult_r;
    logic [CNT_W-1:0]  rst_cnt_r;
    logic              core_reset_n_r;
    pm_ctl_t           pm_r;
    logic [DIV_W-1:0]  div_r [N_CLKGEN];
    logic              reject_r;
    logic              aw_held_r;
    logic [31:0]       aw_addr_r;
    logic              w_held_r;
    logic [31:0]       w_data_r;
    logic [3:0]        w_strb_r;
    logic              bvalid_r;
    logic [1:0]        bresp_r;
    logic              rvalid_r;
    logic [1:0]        rresp_r;
    logic [31:0]       rdata_r;
    logic [31:0]       view [N_REGS];
    logic [N_CLKGEN-1:0] gen_clk;
    logic [CNT_W-1:0]  rel_cnt_r;

    // ratio selection
    wire [MULT_W-1:0] pin_dec  = pin_ratio_decode(clock_ratio_select_pins);
    wire [MULT_W-1:0] mult_nxt = pm_r.ovr ? pm_r.mult : pin_mult_r;
    wire              cnt_done = (rst_cnt_r == CNT_W'(CORE_CNT_LAST));

    // bus decode
    wire        do_wr   = aw_held_r && w_held_r && !bvalid_r;
    wire        do_rd   = arvalid && !rvalid_r;
    wire [2:0]  wr_idx  = aw_addr_r[4:2];
    wire [2:0]  rd_idx  = araddr[4:2];
    wire        wr_hit  = (aw_addr_r[31:5] == 27'h0) && (wr_idx <= IDX_LAST);
    wire        rd_hit  = (araddr[31:5] == 27'h0) && (rd_idx <= IDX_LAST);
    wire        wr_pm   = do_wr && wr_hit && (wr_idx == IDX_PM);
    wire        wr_st   = do_wr && wr_hit && (wr_idx == IDX_STATUS);
    wire        wr_div  = do_wr && wr_hit && (wr_idx >= IDX_DIV0);
    wire [31:0] pm_word = (32'(pm_r.mult) << PM_MULT_POS) | (32'(pm_r.ovr) << PM_OVR_POS);
    wire [31:0] pm_wm   = wmerge(pm_word, w_data_r, w_strb_r);
    wire [MULT_W-1:0] new_mult = pm_wm[PM_MULT_POS +: MULT_W];
    wire        new_ovr = pm_wm[PM_OVR_POS];
    wire        pm_ok   = !new_ovr || ratio_legal(new_mult);
    wire        rej_set = wr_pm && !pm_ok;
    wire        rej_clr = wr_st && w_strb_r[ST_REJECT_POS / 8] && w_data_r[ST_REJECT_POS];
    wire [31:0] st_word = (32'(core_mult_r) << ST_MULT_POS)
                        | (32'(pins_latched_r) << ST_PINS_POS)
                        | (32'(core_reset_n_r) << ST_CORE_POS)
                        | (32'(reject_r) << ST_REJECT_POS);
    wire [31:0] rd_word = rd_hit ? view[rd_idx] : 32'h0000_0000;

    assign view[IDX_PM]     = pm_word;
    assign view[IDX_STATUS] = st_word;

    assign awready         = !aw_held_r && !bvalid_r;
    assign wready          = !w_held_r && !bvalid_r;
    assign bvalid          = bvalid_r;
    assign bresp           = bresp_r;
    assign arready         = !rvalid_r;
    assign rvalid          = rvalid_r;
    assign rresp           = rresp_r;
    assign rdata           = rdata_r;
    assign core_reset_n    = core_reset_n_r;
    assign core_clock_mult = core_mult_r;
    assign serial_port_clk = gen_clk[N_SPORT-1:0];
    assign spi_clk         = gen_clk[SPI_IDX];

    // two-stage synchroniser on the board reset
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ext_sync1_r <= 1'b0;
            ext_sync2_r <= 1'b0;
        end
        else
        begin
            ext_sync1_r <= ext_reset_n;
            ext_sync2_r <= ext_sync1_r;
        end
    end

    // pin ratio follows the pins while reset is held, frozen afterwards
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pins_latched_r <= PINS_RST;
            pin_mult_r     <= PIN_MULT_RST;
        end
        else if (!ext_sync2_r)
        begin
            pins_latched_r <= clock_ratio_select_pins;
            pin_mult_r     <= pin_dec;
        end
    end

    // core reset counter; relies on reset pulses of at least the minimum width
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !ext_sync2_r)
        begin
            rst_cnt_r      <= '0;
            core_reset_n_r <= 1'b0;
        end
        else if (!core_reset_n_r)
        begin
            rst_cnt_r      <= CNT_W'(rst_cnt_r + 1'b1);
            core_reset_n_r <= cnt_done;
        end
    end

    // effective multiplier: software override or pin ratio
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            core_mult_r <= PIN_MULT_RST;
        else
            core_mult_r <= mult_nxt;
    end

    // power management control; out-of-range core periods are refused
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !ext_sync2_r)
            pm_r <= PM_RST;
        else if (wr_pm && pm_ok)
            pm_r <= '{ovr: new_ovr, mult: new_mult};
    end

    // sticky refusal flag, set wins over clear
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            reject_r <= 1'b0;
        else
            reject_r <= rej_set | (reject_r & ~rej_clr);
    end

    // divider ratios, low two byte lanes only
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            for (int i = 0; i < N_CLKGEN; i++)
                div_r[i] <= DIV_RST;
        end
        else
        begin
            for (int i = 0; i < N_CLKGEN; i++)
                if (wr_div && wr_idx == 3'(int'(IDX_DIV0) + i))
                    div_r[i] <= {w_strb_r[1] ? w_data_r[15:8] : div_r[i][15:8],
                                 w_strb_r[0] ? w_data_r[7:0] : div_r[i][7:0]};
        end
    end

    // write channels: address and data held independently until both are in
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_r <= 1'b0;
            aw_addr_r <= 32'h0000_0000;
            w_held_r  <= 1'b0;
            w_data_r  <= 32'h0000_0000;
            w_strb_r  <= 4'h0;
        end
        else
        begin
            if (awvalid && awready)
            begin
                aw_held_r <= 1'b1;
                aw_addr_r <= awaddr;
            end
            else if (do_wr)
                aw_held_r <= 1'b0;
            if (wvalid && wready)
            begin
                w_held_r <= 1'b1;
                w_data_r <= wdata;
                w_strb_r <= wstrb;
            end
            else if (do_wr)
                w_held_r <= 1'b0;
        end
    end

    // write response and read channel
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid_r <= 1'b0;
            bresp_r  <= RESP_OKAY;
            rvalid_r <= 1'b0;
            rresp_r  <= RESP_OKAY;
            rdata_r  <= 32'h0000_0000;
        end
        else
        begin
            if (do_wr)
            begin
                bvalid_r <= 1'b1;
                bresp_r  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end
            else if (bready)
                bvalid_r <= 1'b0;
            if (do_rd)
            begin
                rvalid_r <= 1'b1;
                rresp_r  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
                rdata_r  <= rd_word;
            end
            else if (rready)
                rvalid_r <= 1'b0;
        end
    end

    // port clock generators, four serial ports then spi
    for (genvar g = 0; g < N_CLKGEN; g++)
    begin : g_clkgen
        assign view[int'(IDX_DIV0) + g] = 32'(div_r[g]);
        port_clock_gen u_gen (
            .aclk    (aclk),
            .aresetn (aresetn),
            .run     (core_reset_n_r),
            .mult    (core_mult_r),
            .ratio   (div_r[g]),
            .clk_out (gen_clk[g])
        );
    end

    // checking aids: cycles since the reset pin was first seen high
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !ext_reset_n)
            rel_cnt_r <= '0;
        else if (rel_cnt_r != {CNT_W{1'b1}})
            rel_cnt_r <= CNT_W'(rel_cnt_r + 1'b1);
    end

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_release;
        !core_reset_n_r ##1 core_reset_n_r;
    endsequence

    sequence s_sw_write;
        (wr_pm && new_ovr && pm_ok && ext_sync2_r) ##1 ext_sync2_r;
    endsequence

    a_ratio_latch: assert property ((aresetn && !ext_sync2_r)
        |=> pin_mult_r == $past(pin_dec))
        else $error("pin ratio not tracked during reset");

    a_ratio_frozen: assert property ((ext_sync2_r && $past(ext_sync2_r))
        |-> $stable(pin_mult_r))
        else $error("pin ratio changed after reset release");

    a_pin_3x_ratio: assert property ((!ext_sync2_r && clock_ratio_select_pins == RS_3X)
        |=> pin_mult_r == MULT_3X)
        else $error("pin code did not select 3x ratio");

    a_sw_ratio_set: assert property (s_sw_write |=> core_mult_r == $past(new_mult, 2))
        else $error("software ratio not applied");

    a_core_hold_reset: assert property (!ext_sync2_r |=> !core_reset_n_r)
        else $error("core left reset while board reset held");

    a_core_delay_exact: assert property (s_release
        |-> rel_cnt_r == CNT_W'(CORE_RST_CYCLES + 1))
        else $error("core reset release not 4096 cycles after pin");

    a_core_delay_max: assert property (s_release
        |-> rel_cnt_r <= CNT_W'(CORE_RST_MAX_CYCLES + 1))
        else $error("core reset release later than 4097 cycles");

endmodule

// file: reset_source_model.sv
// board reset source and ratio pin strap model for the sequencer bench
`timescale 1ns/10ps
module reset_source_model
    import clk_seq_pkg::*;
(
    input  wire logic       aclk,
    input  wire logic       rst_req,
    input  wire logic [1:0] pins_req,
    output logic            ext_reset_n,
    output logic [1:0]      clock_ratio_select_pins
);
    int          hold_cnt = 0;
    int          clk_cnt  = 0;
    logic        powered  = 1'b0;
    wire  [31:0] need     = powered ? PLL_SETUP_CYCLES : PLL_LOCK_CYCLES;

    initial ext_reset_n = 1'b0;
    initial clock_ratio_select_pins = 2'h0;

    always @(posedge aclk)
    begin
        clk_cnt  <= clk_cnt + 1;
        hold_cnt <= hold_cnt + 1;
        if (!ext_reset_n)
        begin
            clock_ratio_select_pins <= pins_req;
            if (pins_req != clock_ratio_select_pins)
                hold_cnt <= 0;
            if (!rst_req && hold_cnt >= need && clk_cnt >= INPUT_CLOCK_SETUP_CYCLES)
            begin
                ext_reset_n <= 1'b1;
                hold_cnt    <= 0;
                powered     <= 1'b1;
            end
        end
        else if (rst_req)
        begin
            ext_reset_n <= 1'b0;
            hold_cnt    <= 0;
        end
        else if (hold_cnt == 4)
            clock_ratio_select_pins <= ~clock_ratio_select_pins;
    end
endmodule

// file: test_core_clock_reset_sequencer.sv
// self-checking bench for the core clock and reset sequencer
`timescale 1ns/10ps
module test_core_clock_reset_sequencer
    import clk_seq_pkg::*;
;
    logic               aclk     = 1'b0;
    logic               aresetn  = 1'b0;
    logic               awvalid  = 1'b0;
    logic               wvalid   = 1'b0;
    logic               bready   = 1'b0;
    logic               arvalid  = 1'b0;
    logic               rready   = 1'b0;
    logic               rst_req  = 1'b0;
    logic [1:0]         pins_req = RS_16X;
    logic [31:0]        awaddr   = 32'h0;
    logic [31:0]        wdata    = 32'h0;
    logic [31:0]        araddr   = 32'h0;
    logic               awready, wready, bvalid, arready, rvalid;
    logic               ext_reset_n, core_reset_n, spi_clk;
    logic [1:0]         bresp, rresp, pins;
    logic [31:0]        rdata;
    logic [MULT_W-1:0]  core_clock_mult;
    logic [N_SPORT-1:0] serial_port_clk;
    int                 failures = 0;
    int                 compares = 0;
    logic [MULT_W-1:0]  exp_mult [4] = '{MULT_3X, MULT_16X, MULT_8X, MULT_3X};
    logic [MULT_W-1:0]  sw_mult [4]  = '{5'h09, 5'h10, 5'h0f, 5'h0a};
    logic               sw_ok [4]    = '{1'b0, 1'b0, 1'b1, 1'b1};
    logic [1:0]         codes [3]    = '{RS_8X, 2'h3, RS_3X};

    always #50 aclk = ~aclk;

    core_clock_reset_sequencer u_core_clock_reset_sequencer (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .ext_reset_n(ext_reset_n), .clock_ratio_select_pins(pins),
        .core_reset_n(core_reset_n), .core_clock_mult(core_clock_mult),
        .serial_port_clk(serial_port_clk), .spi_clk(spi_clk));

    reset_source_model u_reset_source_model (
        .aclk(aclk), .rst_req(rst_req), .pins_req(pins_req),
        .ext_reset_n(ext_reset_n), .clock_ratio_select_pins(pins));

    task automatic end_sim();
        if (failures == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_cnt(input string nm, input int e, input int g);
        compares++;
        if (g != e)
        begin
            failures++;
            $display("[FAIL] %s expected %0d seen %0d", nm, e, g);
        end
    endtask

    task automatic timeout(input string nm, input int n, input int lim);
        if (n >= lim)
        begin
            chk_cnt(nm, lim - 1, n);
            end_sim();
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (n = 0; n < 100; n++)
        begin
            @(posedge aclk);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
            if (bvalid === 1'b1)
            begin
                chk_val("bresp", {30'h0, er}, {30'h0, bresp});
                bready <= 1'b0;
                break;
            end
        end
        timeout("write_wait", n, 100);
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e,
                      input logic [1:0] er);
        int n;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (n = 0; n < 100; n++)
        begin
            @(posedge aclk);
            if (arvalid && arready)
                arvalid <= 1'b0;
            if (rvalid === 1'b1)
            begin
                chk_val("rdata", e, rdata & m);
                chk_val("rresp", {30'h0, er}, {30'h0, rresp});
                rready <= 1'b0;
                break;
            end
        end
        timeout("read_wait", n, 100);
    endtask

    function automatic logic [31:0] st(input logic [1:0] p, input logic [MULT_W-1:0] m);
        return {15'h0, 1'b0, 3'h0, 1'b1, 2'h0, p, 3'h0, m};
    endfunction

    task automatic do_reset(input logic [1:0] p, input logic pulse);
        int n;
        pins_req <= p;
        if (pulse)
            rst_req <= 1'b1;
        for (n = 0; n < 3000 && ext_reset_n !== 1'b0; n++)
            @(posedge aclk);
        rst_req <= 1'b0;
        timeout("reset_low", n, 3000);
        for (n = 0; n < 3000; n++)
        begin
            @(posedge aclk);
            if (ext_reset_n === 1'b1)
                break;
        end
        timeout("reset_high", n, 3000);
        chk_val("core_rst_held", 32'h0, {31'h0, core_reset_n});
        chk_val("clks_stopped", 32'h0, {27'h0, spi_clk, serial_port_clk});
        chk_val("pin_mult", {27'h0, exp_mult[p]}, {27'h0, core_clock_mult});
        for (n = 1; n < 5000; n++)
        begin
            @(posedge aclk);
            #1;
            if (core_reset_n === 1'b1)
                break;
        end
        chk_cnt("core_release", CORE_RST_CYCLES, n);
        timeout("core_wait", n, 5000);
    endtask

    task automatic clk_period(input int i, input int e);
        int   n;
        int   t0;
        int   rises;
        logic prv;
        logic cur;
        rises = 0;
        t0    = 0;
        prv   = 1'b1;
        for (n = 0; n < 200 && rises < 2; n++)
        begin
            @(posedge aclk);
            #1;
            cur = (i == SPI_IDX) ? spi_clk : serial_port_clk[i];
            if (cur === 1'b1 && prv === 1'b0)
            begin
                rises++;
                if (rises == 1)
                    t0 = n;
            end
            prv = cur;
        end
        chk_cnt("port_period", e, n - 1 - t0);
    endtask

    initial
    begin
        logic [MULT_W-1:0] m_cur;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        rd(OFS_PM, 32'h1ff, 32'h0, RESP_OKAY);
        for (int i = 0; i < N_CLKGEN; i++)
            rd(OFS_DIV0 + 32'(i * 4), 32'hffff, {16'h0, DIV_RST}, RESP_OKAY);
        do_reset(RS_16X, 1'b0);
        rd(OFS_STATUS, 32'h1_131f, st(RS_16X, MULT_16X), RESP_OKAY);
        wr(OFS_PM, 32'h10a, RESP_OKAY);
        for (int i = 0; i < N_CLKGEN; i++)
        begin
            wr(OFS_DIV0 + 32'(i * 4), 32'(40 + 20 * i), RESP_OKAY);
            rd(OFS_DIV0 + 32'(i * 4), 32'hffff, 32'(40 + 20 * i), RESP_OKAY);
            clk_period(i, 4 + 2 * i);
        end
        m_cur = 5'h0a;
        for (int k = 0; k < 4; k++)
        begin
            wr(OFS_PM, {23'h0, 1'b1, 3'h0, sw_mult[k]}, RESP_OKAY);
            if (sw_ok[k])
                m_cur = sw_mult[k];
            repeat (2) @(posedge aclk);
            chk_val("sw_mult", {27'h0, m_cur}, {27'h0, core_clock_mult});
            rd(OFS_STATUS, 32'h1_001f, {15'h0, !sw_ok[k], 11'h0, m_cur}, RESP_OKAY);
            wr(OFS_STATUS, 32'h1_0000, RESP_OKAY);
        end
        wr(32'h1c, 32'hffff_ffff, RESP_SLVERR);
        rd(32'h1c, 32'hffff_ffff, 32'h0, RESP_SLVERR);
        rd(32'h20, 32'hffff_ffff, 32'h0, RESP_SLVERR);
        for (int k = 0; k < 3; k++)
        begin
            do_reset(codes[k], 1'b1);
            rd(OFS_STATUS, 32'h1_131f, st(codes[k], exp_mult[codes[k]]), RESP_OKAY);
            rd(OFS_PM, 32'h1ff, 32'h0, RESP_OKAY);
            rd(OFS_DIV0, 32'hffff, 32'd40, RESP_OKAY);
        end
        end_sim();
    end
endmodule
